// ==== shared/stl_params.svh ====
`ifndef STL_PARAMS_SVH
`define STL_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define STL_TICK_MS 400
`define STL_CLK_KHZ 125000
// Updates per second is 5/2
`define STL_UPD_NUM 5
`define STL_UPD_DEN 2
`define STL_SECS_PER_SEC 1
`define STL_SECS_PER_MIN 60
`define STL_SECS_PER_HOUR 3600
`define STL_SCALE_ONE 1000

// ****************************************
// Total range
// ****************************************
`define STL_TOTAL_MAX 999999
`define STL_TOTAL_MIN -99999
`define STL_TOTAL_SPAN 1099999
`define STL_DP_MAX 3'd4
`define STL_SEG_MAX 4'd9
`define STL_POINTS 10

// ****************************************
// Register offsets
// ****************************************
`define STL_OFF_CTRL 12'h000
`define STL_OFF_SCALE 12'h004
`define STL_OFF_CUTOFF 12'h008
`define STL_OFF_DECPOS 12'h00C
`define STL_OFF_ALARM 12'h010
`define STL_OFF_SEGCNT 12'h014
`define STL_OFF_STATUS 12'h018
`define STL_OFF_MASK 12'h01C
`define STL_OFF_TOTAL 12'h020
`define STL_OFF_LINOUT 12'h024
`define STL_OFF_OVF 12'h028
`define STL_OFF_POINT 12'h040
`define STL_OFF_POINT_END 12'h090

// ****************************************
// Fields
// ****************************************
`define STL_CTRL_PER_LSB 0
`define STL_CTRL_RUN 2
`define STL_CTRL_REV 3
`define STL_CTRL_ALSRC 4
`define STL_CTRL_CLEAR 5
`define STL_DP_TOT_LSB 0
`define STL_DP_IN_LSB 4
`define STL_EV_WRAP 0
`define STL_EV_ALARM 1
`define STL_EV_CLEAR 2
`define STL_EV_LIN 3

// ****************************************
// Reset values
// ****************************************
`define STL_RST_CTRL 6'h04
`define STL_RST_SCALE 32'h0000_03E8
`define STL_RST_SEGCNT 4'h1

`endif

// ==== shared/stl_pkg.sv ====
package stl_pkg;
   typedef enum logic [1:0] {
      STL_PER_SEC,
      STL_PER_MIN,
      STL_PER_HOUR,
      STL_PER_HOUR_ALT
   } stl_period_type;

   typedef enum logic [2:0] {
      STL_LIN_IDLE,
      STL_LIN_FIRST,
      STL_LIN_SECOND,
      STL_LIN_SCAN,
      STL_LIN_DIV
   } stl_lin_state_type;
endpackage : stl_pkg

// ==== hw/stl_point_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module stl_point_mem #(
   parameter int LANE_W = 32,
   parameter int LANES = 2,
   parameter int DEPTH = 10
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Write port
   input wire logic [LANES-1:0] wr_lane_i,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
   input wire logic [LANE_W-1:0] wr_data_i,
   // Read port
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
   output logic [LANES*LANE_W-1:0] rd_data_o
);
   logic [LANES*LANE_W-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys_i) begin
      for (int i = 0; i < LANES; i++) begin
         if (wr_lane_i[i]) begin
            mem[wr_addr_i][i*LANE_W +: LANE_W] <= wr_data_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule : stl_point_mem
`default_nettype wire

// ==== hw/stl_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module stl_divider #(
   parameter int W = 64
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Request
   input wire logic start_i,
   input wire logic [W-1:0] dividend_i,
   input wire logic [W-1:0] divisor_i,
   // Answer
   output logic done_o,
   output logic [W-1:0] quotient_o,
   output logic [W-1:0] remainder_o
);
   logic [$clog2(W+1)-1:0] count;
   logic busy;
   logic [W-1:0] divisor;
   logic [W:0] shifted;

   assign shifted = {remainder_o, quotient_o[W-1]};

   // Restoring divide, one quotient bit a cycle
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= '0;
         busy <= 1'b0;
         done_o <= 1'b0;
         divisor <= '0;
         quotient_o <= '0;
         remainder_o <= '0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            busy <= 1'b1;
            count <= ($clog2(W+1))'(W);
            divisor <= divisor_i;
            quotient_o <= dividend_i;
            remainder_o <= '0;
         end else if (busy) begin
            if (shifted >= {1'b0, divisor}) begin
               remainder_o <= W'(shifted - {1'b0, divisor});
               quotient_o <= {quotient_o[W-2:0], 1'b1};
            end else begin
               remainder_o <= shifted[W-1:0];
               quotient_o <= {quotient_o[W-2:0], 1'b0};
            end
            count <= count - 1'b1;
            if (count == 1) begin
               busy <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule : stl_divider
`default_nettype wire

// ==== hw/stl_totalizer.sv ====
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`include "stl_params.svh"
`timescale 1ns/100ps
`default_nettype none
module stl_totalizer #(
   parameter int unsigned TICK_CYCLES = `STL_TICK_MS * `STL_CLK_KHZ
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic [11:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Front end reading and clear requests
   input wire logic signed [31:0] reading_i,
   input wire logic remote_clear_i,
   input wire logic panel_clear_i,
   // Retention store
   input wire logic restore_i,
   input wire logic signed [31:0] restore_total_i,
   output logic signed [31:0] retained_total_o,
   // Indications
   output logic overflow_o,
   output logic total_flash_o,
   output logic alarm_o,
   output logic signed [31:0] lin_display_o,
   output logic [2:0] total_dp_o,
   output logic [2:0] input_dp_o,
   output logic irq_o
);
   // ****************************************
   // Registers
   // ****************************************
   logic [5:0] ctrl;
   logic [31:0] total_scale_factor;
   logic signed [31:0] low_signal_cutoff;
   logic signed [31:0] alarm_level;
   logic [3:0] seg_count;
   logic [3:0] status;
   logic [3:0] mask;
   logic [3:0] events;
   logic signed [31:0] total;
   logic signed [7:0] wrap_count;
   logic [31:0] tick_cnt;
   logic tick;
   logic bus_wr;
   logic bus_setup;
   logic addr_ok;
   logic [31:0] next_prdata;
   logic clear_req;
   stl_pkg::stl_period_type accumulation_period_select;

   assign accumulation_period_select = stl_pkg::stl_period_type'(ctrl[`STL_CTRL_PER_LSB +: 2]);
   assign bus_setup = psel_i && !penable_i;
   assign bus_wr = psel_i && penable_i && pwrite_i;
   assign addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i <= `STL_OFF_OVF
      || (paddr_i >= `STL_OFF_POINT && paddr_i < `STL_OFF_POINT_END));
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_ok;
   assign clear_req = remote_clear_i || panel_clear_i
      || (bus_wr && paddr_i == `STL_OFF_CTRL && pwdata_i[`STL_CTRL_CLEAR]);

   // ****************************************
   // Bus writes
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= `STL_RST_CTRL;
         total_scale_factor <= `STL_RST_SCALE;
         low_signal_cutoff <= '0;
         alarm_level <= '0;
         seg_count <= `STL_RST_SEGCNT;
         total_dp_o <= '0;
         input_dp_o <= '0;
         mask <= '0;
      end else if (bus_wr) begin
         unique case (paddr_i)
            `STL_OFF_CTRL: ctrl <= {1'b0, pwdata_i[4:0]};
            `STL_OFF_SCALE: total_scale_factor <= pwdata_i;
            `STL_OFF_CUTOFF: low_signal_cutoff <= pwdata_i;
            `STL_OFF_ALARM: alarm_level <= pwdata_i;
            `STL_OFF_DECPOS: begin
               // Positions above four are held at four
               total_dp_o <= (pwdata_i[`STL_DP_TOT_LSB +: 3] > `STL_DP_MAX) ? `STL_DP_MAX
                  : pwdata_i[`STL_DP_TOT_LSB +: 3];
               input_dp_o <= (pwdata_i[`STL_DP_IN_LSB +: 3] > `STL_DP_MAX) ? `STL_DP_MAX
                  : pwdata_i[`STL_DP_IN_LSB +: 3];
            end
            `STL_OFF_SEGCNT: begin
               if (pwdata_i[3:0] == 4'h0) begin
                  seg_count <= 4'h1;
               end else if (pwdata_i[3:0] > `STL_SEG_MAX) begin
                  seg_count <= `STL_SEG_MAX;
               end else begin
                  seg_count <= pwdata_i[3:0];
               end
            end
            `STL_OFF_MASK: mask <= pwdata_i[3:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Bus reads, latched in the setup cycle
   // ****************************************
   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (paddr_i)
         `STL_OFF_CTRL: next_prdata = {26'h0, ctrl};
         `STL_OFF_SCALE: next_prdata = total_scale_factor;
         `STL_OFF_CUTOFF: next_prdata = low_signal_cutoff;
         `STL_OFF_ALARM: next_prdata = alarm_level;
         `STL_OFF_DECPOS: next_prdata = {25'h0, input_dp_o, 1'b0, total_dp_o};
         `STL_OFF_SEGCNT: next_prdata = {28'h0, seg_count};
         `STL_OFF_STATUS: next_prdata = {28'h0, status};
         `STL_OFF_MASK: next_prdata = {28'h0, mask};
         `STL_OFF_TOTAL: next_prdata = total;
         `STL_OFF_LINOUT: next_prdata = lin_display_o;
         `STL_OFF_OVF: next_prdata = {30'h0, total_flash_o, overflow_o};
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= '0;
      end else if (bus_setup) begin
         prdata_o <= next_prdata;
      end
   end

   // ****************************************
   // Update tick
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
         tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
      end
   end

   // ****************************************
   // Accumulation
   // ****************************************
   logic signed [63:0] residue;
   logic signed [63:0] numer;
   logic signed [31:0] eff_reading;
   logic [63:0] period_div;
   logic acc_busy;
   logic acc_neg;
   logic acc_start;
   logic acc_done;
   logic [63:0] acc_quo;
   logic [63:0] acc_rem;
   logic signed [63:0] acc_step;
   logic signed [63:0] sum;

   assign eff_reading = ctrl[`STL_CTRL_REV] ? -reading_i : reading_i;
   // Scale is fixed point, 1000 meaning 1.000; twice the product over five per period second
   // Operands widened first, a 33-bit product would overflow with large scale factors
   assign numer = 64'(eff_reading) * 64'($signed({1'b0, total_scale_factor}))
      * 64'(`STL_UPD_DEN) + residue;
   always_comb begin
      unique case (accumulation_period_select)
         stl_pkg::STL_PER_SEC: period_div = 64'(`STL_UPD_NUM * `STL_SECS_PER_SEC * `STL_SCALE_ONE);
         stl_pkg::STL_PER_MIN: period_div = 64'(`STL_UPD_NUM * `STL_SECS_PER_MIN * `STL_SCALE_ONE);
         default: period_div = 64'(`STL_UPD_NUM * `STL_SECS_PER_HOUR * `STL_SCALE_ONE);
      endcase
   end
   // Cutoff compares the raw reading, so a negative cutoff lets negative readings count down
   assign acc_start = tick && ctrl[`STL_CTRL_RUN] && (reading_i >= low_signal_cutoff) && !clear_req;
   assign acc_step = acc_neg ? -$signed(acc_quo) : $signed(acc_quo);
   assign sum = 64'(total) + acc_step;

   stl_divider #(.W(64)) u_acc_div (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .start_i(acc_start),
      .dividend_i(numer[63] ? -numer : numer),
      .divisor_i(period_div),
      .done_o(acc_done),
      .quotient_o(acc_quo),
      .remainder_o(acc_rem)
   );

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         total <= '0;
         residue <= '0;
         wrap_count <= '0;
         acc_busy <= 1'b0;
         acc_neg <= 1'b0;
      end else if (clear_req) begin
         total <= '0;
         residue <= '0;
         wrap_count <= '0;
         acc_busy <= 1'b0;
      end else if (restore_i) begin
         total <= restore_total_i;
         residue <= '0;
         acc_busy <= 1'b0;
      end else if (acc_start) begin
         acc_busy <= 1'b1;
         acc_neg <= numer[63];
      end else if (acc_done && acc_busy) begin
         acc_busy <= 1'b0;
         residue <= acc_neg ? -$signed(acc_rem) : $signed(acc_rem);
         if (sum > `STL_TOTAL_MAX) begin
            total <= 32'(sum - `STL_TOTAL_SPAN);
            wrap_count <= wrap_count + 1'b1;
         end else if (sum < `STL_TOTAL_MIN) begin
            total <= 32'(sum + `STL_TOTAL_SPAN);
            wrap_count <= wrap_count - 1'b1;
         end else begin
            total <= 32'(sum);
         end
      end
   end

   assign retained_total_o = total;
   assign overflow_o = (wrap_count != 8'sh00);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         total_flash_o <= 1'b0;
      end else if (!overflow_o) begin
         total_flash_o <= 1'b0;
      end else if (tick) begin
         total_flash_o <= !total_flash_o;
      end
   end

   // ****************************************
   // Alarm compare
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_o <= 1'b0;
      end else if (tick) begin
         alarm_o <= (ctrl[`STL_CTRL_ALSRC] ? total : reading_i) >= alarm_level;
      end
   end

   // ****************************************
   // Linearizer
   // ****************************************
   stl_pkg::stl_lin_state_type lin_state;
   logic [3:0] seg_k;
   logic [3:0] rd_addr;
   logic [63:0] rd_pair;
   logic signed [31:0] lin_in;
   logic signed [31:0] x0, y0, x1, y1;
   logic seg_stop;
   logic signed [63:0] lin_num;
   logic signed [63:0] lin_den;
   logic lin_start;
   logic lin_done;
   logic lin_neg;
   logic [63:0] lin_quo;
   logic pt_write;

   assign pt_write = bus_wr && paddr_i >= `STL_OFF_POINT && paddr_i < `STL_OFF_POINT_END;
   // Memory answers a cycle late, so the scan fetches one pair ahead
   assign rd_addr = (lin_state == stl_pkg::STL_LIN_FIRST) ? 4'h0
      : (lin_state == stl_pkg::STL_LIN_SCAN && seg_k < 4'h8) ? seg_k + 4'h2 : 4'h1;
   assign x1 = rd_pair[31:0];
   assign y1 = rd_pair[63:32];
   // Below the first point or past the last the nearest segment extrapolates
   assign seg_stop = (seg_k == seg_count - 1'b1)
      || ((x1 > x0) ? (lin_in <= x1) : (lin_in >= x1));
   assign lin_num = (64'(lin_in) - 64'(x0)) * (64'(y1) - 64'(y0));
   assign lin_den = 64'(x1) - 64'(x0);
   assign lin_start = (lin_state == stl_pkg::STL_LIN_SCAN) && seg_stop && (lin_den != 64'sh0);

   stl_point_mem #(.LANE_W(32), .LANES(2), .DEPTH(`STL_POINTS)) u_points (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .wr_lane_i({pt_write && paddr_i[2], pt_write && !paddr_i[2]}),
      .wr_addr_i(4'(paddr_i[7:3] - 5'h08)),
      .wr_data_i(pwdata_i),
      .rd_addr_i(rd_addr),
      .rd_data_o(rd_pair)
   );

   stl_divider #(.W(64)) u_lin_div (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .start_i(lin_start),
      .dividend_i(lin_num[63] ? -lin_num : lin_num),
      .divisor_i(lin_den[63] ? -lin_den : lin_den),
      .done_o(lin_done),
      .quotient_o(lin_quo),
      .remainder_o()
   );

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lin_state <= stl_pkg::STL_LIN_IDLE;
         seg_k <= '0;
         lin_in <= '0;
         x0 <= '0;
         y0 <= '0;
         lin_neg <= 1'b0;
         lin_display_o <= '0;
      end else begin
         unique case (lin_state)
            stl_pkg::STL_LIN_IDLE: begin
               if (tick) begin
                  lin_in <= reading_i;
                  seg_k <= '0;
                  lin_state <= stl_pkg::STL_LIN_FIRST;
               end
            end
            stl_pkg::STL_LIN_FIRST: lin_state <= stl_pkg::STL_LIN_SECOND;
            stl_pkg::STL_LIN_SECOND: begin
               x0 <= rd_pair[31:0];
               y0 <= rd_pair[63:32];
               lin_state <= stl_pkg::STL_LIN_SCAN;
            end
            stl_pkg::STL_LIN_SCAN: begin
               if (!seg_stop) begin
                  x0 <= x1;
                  y0 <= y1;
                  seg_k <= seg_k + 1'b1;
               end else if (lin_den == 64'sh0) begin
                  // Zero-width segment shows its start value
                  lin_display_o <= y0;
                  lin_state <= stl_pkg::STL_LIN_IDLE;
               end else begin
                  lin_neg <= lin_num[63] ^ lin_den[63];
                  lin_state <= stl_pkg::STL_LIN_DIV;
               end
            end
            stl_pkg::STL_LIN_DIV: begin
               if (lin_done) begin
                  lin_display_o <= y0 + (lin_neg ? -$signed(lin_quo[31:0]) : $signed(lin_quo[31:0]));
                  lin_state <= stl_pkg::STL_LIN_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   logic alarm_prev;

   always_comb begin
      events = '0;
      events[`STL_EV_WRAP] = acc_done && acc_busy && !clear_req && !restore_i
         && (sum > `STL_TOTAL_MAX || sum < `STL_TOTAL_MIN);
      events[`STL_EV_ALARM] = alarm_o && !alarm_prev;
      events[`STL_EV_CLEAR] = clear_req;
      events[`STL_EV_LIN] = (lin_state == stl_pkg::STL_LIN_DIV) && lin_done;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status <= '0;
         alarm_prev <= 1'b0;
      end else begin
         alarm_prev <= alarm_o;
         // A new event wins over a write-one clear in the same cycle
         status <= (status & ~((bus_wr && paddr_i == `STL_OFF_STATUS) ? pwdata_i[3:0] : 4'h0)) | events;
      end
   end

   assign irq_o = |(status & mask);

   // ****************************************
   // Checks
   // ****************************************
   chk_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      tick |=> !tick) else $error("tick lasted more than one cycle");
   chk_start_on_tick: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      u_acc_div.start_i |-> tick && ctrl[`STL_CTRL_RUN]) else $error("accumulation began off a tick");
   chk_clear_zeroes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      clear_req |=> total == 32'sh0 && !overflow_o) else $error("clear did not zero the total");
   chk_cutoff_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      tick && reading_i < low_signal_cutoff && !acc_busy |=> !acc_busy) else $error("accumulated below cutoff");
   chk_total_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $changed(total) && !$past(restore_i) |-> total <= `STL_TOTAL_MAX && total >= `STL_TOTAL_MIN)
      else $error("total left its range");
   chk_flash_ovf: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      total_flash_o |-> $past(overflow_o)) else $error("flash without overflow");
   chk_alarm_tick: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $changed(alarm_o) |-> $past(tick)) else $error("alarm moved between ticks");
   chk_alarm_source: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      tick && ctrl[`STL_CTRL_ALSRC] |=> alarm_o == ($past(total) >= $past(alarm_level)))
      else $error("alarm ignored the total");
   chk_seg_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      lin_state == stl_pkg::STL_LIN_SCAN |-> seg_k < seg_count) else $error("segment past active count");
   chk_lin_finish: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      lin_start |-> ##[60:70] lin_state == stl_pkg::STL_LIN_IDLE) else $error("interpolation overran");
endmodule : stl_totalizer
`default_nettype wire

// ==== tb/stl_front_end.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Measurement front end model
// ****************************************
module stl_front_end (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Conversion request from bench
   input wire logic load_i,
   input wire logic signed [31:0] value_i,
   // Reading to the block
   output logic signed [31:0] reading_o
);
   // Holds the last conversion, as the converter does between results
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reading_o <= 32'sh0000_0000;
      end else if (load_i) begin
         reading_o <= value_i;
      end
   end
endmodule : stl_front_end
`default_nettype wire

// ==== tb/stl_totalizer_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module stl_totalizer_tb_top;
   // Short tick keeps the run brief
   localparam int TK = 200;
   logic clk_sys_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, ld = 0, rclr = 0, pclr = 0, rst = 0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0000_0000, prd, prdata;
   logic signed [31:0] val = 32'sh0000_0000, rv = 32'sh0000_0000, rdg, tot, lin;
   logic pready, perr, pslv, ovf, fl, alm, irq;
   logic [2:0] tdp, idp;
   int cyc = 0, n_errors = 0, cmp_count = 0, seed = 84330, r;
   initial forever #4 clk_sys_i = ~clk_sys_i;
   // Tick phase is known from the cycle count since release
   always @(posedge clk_sys_i) cyc <= rst_n_i ? cyc + 1 : 0;
   stl_front_end stl_front_end_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .load_i(ld), .value_i(val),
      .reading_o(rdg));
   stl_totalizer #(.TICK_CYCLES(TK)) stl_totalizer_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(pa),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslv), .reading_i(rdg), .remote_clear_i(rclr), .panel_clear_i(pclr), .restore_i(rst),
      .restore_total_i(rv), .retained_total_o(tot), .overflow_o(ovf), .total_flash_o(fl), .alarm_o(alm),
      .lin_display_o(lin), .total_dp_o(tdp), .input_dp_o(idp), .irq_o(irq));
   // ****************************************
   // Tasks
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_i) {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
      @(posedge clk_sys_i) pen <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      prd = prdata;
      perr = pslv;
      {psel, pen} <= 2'b00;
   endtask : apb
   task tick_wait(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         while (cyc % TK != 100) @(posedge clk_sys_i);
      end
   endtask : tick_wait
   task load(input logic signed [31:0] v);
      @(posedge clk_sys_i) {ld, val} <= {1'b1, v};
      @(posedge clk_sys_i) ld <= 1'b0;
   endtask : load
   task restore(input logic signed [31:0] v);
      @(posedge clk_sys_i) {rst, rv} <= {1'b1, v};
      @(posedge clk_sys_i) rst <= 1'b0;
   endtask : restore
   // Changes land mid-period so the next tick sees them
   task go(input logic [31:0] ctl, input logic signed [31:0] v, input int n);
      tick_wait(1);
      load(v);
      apb(1'b1, 12'h000, ctl | 32'h0000_0020);
      tick_wait(n);
   endtask : go
   function automatic logic [31:0] acc(input longint rr, input int p, input int n);
      longint s;
      s = (p == 0) ? 1 : (p == 1) ? 60 : 3600;
      return 32'(n * rr * 120000 / (5000 * s));
   endfunction : acc
   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(prd, 32'h0000_0004);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(prd, 32'h0000_03E8);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk({31'h0, perr}, 32'h0000_0001);
      apb(1'b1, 12'h00C, 32'h0000_0037);
      @(posedge clk_sys_i);
      chk({26'h0, tdp, idp}, 32'h0000_0023);
      // Rising input points, gentle slopes
      apb(1'b1, 12'h040, 32'h0000_0000);
      apb(1'b1, 12'h044, 32'h0000_0000);
      apb(1'b1, 12'h048, 32'h0000_03E8);
      apb(1'b1, 12'h04C, 32'h0000_1388);
      apb(1'b1, 12'h004, 32'h0000_EA60);
      for (int p = 0; p < 3; p++) begin
         r = 1000 + ($unsigned($random(seed)) % 8000);
         go(32'h0000_0004 | p, r, 3);
         chk(tot, acc(r, p, 3));
         chk(lin, 32'(r * 5));
      end
      apb(1'b1, 12'h004, 32'h0000_03E8);
      apb(1'b1, 12'h008, 32'h0000_03E8);
      go(32'h0000_0004, 32'sh0000_01F4, 2);
      chk(tot, 32'h0000_0000);
      load(32'sh0000_07D0);
      tick_wait(1);
      chk(tot, 32'h0000_0320);
      apb(1'b1, 12'h008, 32'hFFFF_F830);
      go(32'h0000_0004, 32'shFFFF_FC18, 2);
      chk(tot, 32'hFFFF_FCE0);
      load(32'shFFFF_F448);
      tick_wait(2);
      chk(tot, 32'hFFFF_FCE0);
      apb(1'b1, 12'h008, 32'h0000_0000);
      apb(1'b1, 12'h01C, 32'h0000_0001);
      go(32'h0000_0004, 32'sh0000_03E8, 0);
      restore(32'sh000F_4178);
      tick_wait(1);
      chk(tot, 32'hFFFE_7A29);
      chk({30'h0, ovf, irq}, 32'h0000_0003);
      apb(1'b1, 12'h000, 32'h0000_000C);
      tick_wait(1);
      chk(tot, 32'h000F_4178);
      chk({30'h0, ovf, fl}, 32'h0000_0000);
      apb(1'b1, 12'h018, 32'h0000_0001);
      @(posedge clk_sys_i);
      chk({31'h0, irq}, 32'h0000_0000);
      for (int k = 0; k < 2; k++) begin
         restore(32'sh0000_04D2);
         @(posedge clk_sys_i) {rclr, pclr} <= (k == 0) ? 2'b10 : 2'b01;
         chk(tot, 32'h0000_04D2);
         @(posedge clk_sys_i) {rclr, pclr} <= 2'b00;
         @(posedge clk_sys_i);
         chk(tot, 32'h0000_0000);
      end
      apb(1'b1, 12'h010, 32'h0000_0064);
      go(32'h0000_0014, 32'sh0000_0032, 8);
      chk({31'h0, alm}, 32'h0000_0001);
      // Second segment: third point and two active segments
      apb(1'b1, 12'h050, 32'h0000_0BB8);
      apb(1'b1, 12'h054, 32'h0000_1770);
      apb(1'b1, 12'h014, 32'h0000_0002);
      load(32'sh0000_07D0);
      tick_wait(1);
      chk(lin, 32'h0000_157C);
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_errors++;
      print_verdict();
   end
endmodule : stl_totalizer_tb_top
`default_nettype wire
